// [hdl/scl_pkg.sv]
// scl_pkg: constants, pin map and state types of the SPI configuration loader.
// assumes a 50 MHz system clock; all times are turned into cycle counts here.
package scl_pkg;

    // ==================================================================
    // clock and timing
    localparam int SYS_CLK_HZ     = 50_000_000;
    localparam int SLOW_SCK_HZ    = 4_000_000;
    localparam int FAST_SCK_HZ    = 16_000_000;
    // half periods round up so the link never runs above its target rate
    localparam int HALF_SLOW_INT  = (SYS_CLK_HZ + 2 * SLOW_SCK_HZ - 1) / (2 * SLOW_SCK_HZ);
    localparam int HALF_FAST_INT  = (SYS_CLK_HZ + 2 * FAST_SCK_HZ - 1) / (2 * FAST_SCK_HZ);
    localparam logic [2:0] HALF_SLOW = 3'(HALF_SLOW_INT);
    localparam logic [2:0] HALF_FAST = 3'(HALF_FAST_INT);
    localparam int START_WAIT_US  = 115;
    localparam int START_WAIT_CYC = (START_WAIT_US * (SYS_CLK_HZ / 1_000_000));
    localparam int USER_DELAY_NS  = 320;
    localparam int USER_DELAY_INT = (USER_DELAY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    localparam logic [4:0] USER_DELAY_CYC = 5'(USER_DELAY_INT);

    // ==================================================================
    // prom commands and image layout
    localparam logic [7:0]  CMD_READ      = 8'h03;
    localparam logic [7:0]  CMD_PWR_DOWN  = 8'hB9;
    localparam logic [7:0]  IMAGE_ADDR_B  = 8'h00;
    localparam logic [1:0]  CMD_LAST_IDX  = 2'h3;
    localparam int          FAST_FLAG_BIT = 0;
    localparam logic [15:0] EMPTY_LEN     = 16'hFFFF;
    localparam logic [15:0] ZERO_LEN      = 16'h0000;
    localparam logic [15:0] ONE_LEN       = 16'h0001;
    localparam logic [2:0]  MAX_RETRY     = 3'h5;
    localparam logic [2:0]  LAST_BIT      = 3'h7;

    // ==================================================================
    // pin map of the dual-purpose spi pins
    localparam int PIN_CS   = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_MISO = 3;
    localparam int PIN_N    = 4;
    localparam int SYNC_RST = 4;

    // ==================================================================
    // states
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_WAIT   = 8'h02,
        ST_CMD    = 8'h04,
        ST_STREAM = 8'h08,
        ST_GAP    = 8'h10,
        ST_PDN    = 8'h20,
        ST_DONE   = 8'h40,
        ST_FAIL   = 8'h80
    } scl_state_t;

    typedef enum logic [4:0] {
        PH_HDR  = 5'h01,
        PH_LENH = 5'h02,
        PH_LENL = 5'h04,
        PH_DATA = 5'h08,
        PH_SUM  = 5'h10
    } scl_phase_t;

endpackage : scl_pkg

// [hdl/scl_sync.sv]
// scl_sync: two-flop synchroniser for a group of asynchronous levels.
// assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ps
`default_nettype none

module scl_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ==================================================================
    // two stages; first stage read only by the second
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // scl_sync

`default_nettype wire

// [hdl/scl_loader.sv]
// scl_loader: power-on configuration loader, spi master or slave.
// assumes pins arrive asynchronous and are synchronised here; fabric side
// ports (user_*, cfg_*) are on sys_clk.
//
// Function
// - nothing held after power-on; every release of config reset starts a full load
// - chip select sampled at config reset release: high master, low slave
// - after configuration the four spi pins go to user i/o
// - master mode: drive spi pins and issue read command after release
// - master spi clock runs near 3.6 MHz or at 12.5 MHz (half periods of 7 or 2 cycles)
// - master sends prom deep power-down after last byte, before pin release
// - checksum compared with stored one; done raised on match, or at once for an empty request
// - checksum covers logic and embedded ram data
// - on mismatch the load restarts, at most five times
// - swapped mosi/miso still raises done for an empty request
// - master starts slow, header byte decides switch to fast rate
// - master waits 115 us after release before first clock edge
// - user operation begins 320 ns after done rises
`timescale 1ns/1ps
`default_nettype none

module scl_loader
    import scl_pkg::*;
#(
    parameter int START_WAIT = START_WAIT_CYC
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // configuration reset pin
    input  wire logic              config_reset_n,
    // spi pins: cs, sclk, mosi, miso
    input  wire logic [PIN_N-1:0]  pin_i,
    output logic      [PIN_N-1:0]  pin_o,
    output logic      [PIN_N-1:0]  pin_oe_n,
    // user i/o after handover
    input  wire logic [PIN_N-1:0]  user_pin_o,
    input  wire logic [PIN_N-1:0]  user_pin_oe_n,
    output logic      [PIN_N-1:0]  user_pin_i,
    // configuration stream and status
    output logic      [7:0]        cfg_data,
    output logic                   cfg_valid,
    output logic                   cfg_done,
    output logic                   cfg_fail,
    output logic                   user_mode,
    output logic                   master_mode
);

    // ==================================================================
    // input synchronisers
    logic [PIN_N:0] sync_w;
    logic           rst_n_s;
    logic [PIN_N-1:0] pin_s;

    scl_sync #(.WIDTH(PIN_N + 1)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .async_i ({config_reset_n, pin_i}),
        .sync_o  (sync_w)
    );

    assign rst_n_s = sync_w[SYNC_RST];
    assign pin_s   = sync_w[PIN_N-1:0];

    // ==================================================================
    // state
    scl_state_t  st_q;
    scl_state_t  next_q;
    scl_phase_t  ph_q;
    logic [15:0] wait_cnt_q;
    logic [1:0]  cmd_idx_q;
    logic [15:0] len_q;
    logic [7:0]  len_hi_q;
    logic [7:0]  sum_q;
    logic [2:0]  retry_q;
    logic        fast_q;
    logic [4:0]  user_cnt_q;

    // master byte engine
    logic        m_busy_q;
    logic        m_done_q;
    logic        sclk_q;
    logic [2:0]  div_q;
    logic [2:0]  m_bit_q;
    logic [7:0]  m_tx_q;
    logic [7:0]  m_rx_q;

    // slave byte engine
    logic        s_sclk_prev_q;
    logic [2:0]  s_bit_q;
    logic [7:0]  s_rx_q;
    logic        s_done_q;

    // ==================================================================
    // decode
    wire         in_xfer    = (st_q == ST_CMD) || (st_q == ST_STREAM) || (st_q == ST_PDN);
    wire [2:0]   half       = fast_q ? HALF_FAST : HALF_SLOW;
    wire         half_tick  = (div_q == half - 3'h1);
    wire         m_start    = master_mode && in_xfer && !m_busy_q && !m_done_q;
    wire [7:0]   cmd_byte   = (cmd_idx_q == 2'h0) ? CMD_READ : IMAGE_ADDR_B;
    wire [7:0]   tx_byte    = (st_q == ST_PDN) ? CMD_PWR_DOWN :
                              (st_q == ST_CMD) ? cmd_byte : 8'h00;
    wire         byte_done  = master_mode ? m_done_q : s_done_q;
    wire [7:0]   rx_byte    = master_mode ? m_rx_q : s_rx_q;
    wire         s_rise     = pin_s[PIN_SCLK] && !s_sclk_prev_q;
    wire         s_active   = !master_mode && (st_q == ST_STREAM) && !pin_s[PIN_CS];
    wire         got        = byte_done && (st_q == ST_STREAM);
    wire [15:0]  len_full   = {len_hi_q, rx_byte};
    wire         empty_req  = got && (ph_q == PH_LENL) && (len_full == EMPTY_LEN);
    wire         sum_ok     = got && (ph_q == PH_SUM) && (rx_byte == sum_q);
    wire         sum_bad    = got && (ph_q == PH_SUM) && (rx_byte != sum_q);
    wire         finish     = empty_req || sum_ok;
    wire         wait_end   = (wait_cnt_q == 16'(START_WAIT - 1));
    wire         gap_end    = (wait_cnt_q == 16'(HALF_SLOW - 3'h1));

    // ==================================================================
    // pin muxing: loader until handover, then user
    wire             drive_m   = master_mode && (st_q != ST_IDLE) && !user_mode;
    wire             cs_lvl    = !(master_mode && in_xfer);
    wire [PIN_N-1:0] ld_o      = {1'b0, m_tx_q[7], sclk_q, cs_lvl};
    wire [PIN_N-1:0] ld_oe_n   = {1'b1, {3{!drive_m}}};
    wire [PIN_N-1:0] pin_o_d   = user_mode ? user_pin_o : ld_o;
    wire [PIN_N-1:0] pin_oe_d  = user_mode ? user_pin_oe_n : ld_oe_n;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_o      <= '0;
            pin_oe_n   <= '1;
            user_pin_i <= '0;
        end
        else
        begin
            pin_o      <= pin_o_d;
            pin_oe_n   <= pin_oe_d;
            user_pin_i <= user_mode ? pin_s : '0;
        end
    end

    // ==================================================================
    // master byte engine, spi mode 0, msb first
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            m_busy_q <= 1'b0;
            m_done_q <= 1'b0;
            sclk_q   <= 1'b0;
            div_q    <= '0;
            m_bit_q  <= '0;
            m_tx_q   <= '0;
            m_rx_q   <= '0;
        end
        else
        begin
            m_done_q <= 1'b0;
            if (!rst_n_s || !in_xfer)
            begin
                m_busy_q <= 1'b0;
                sclk_q   <= 1'b0;
                div_q    <= '0;
            end
            else if (m_start)
            begin
                m_busy_q <= 1'b1;
                m_tx_q   <= tx_byte;
                m_bit_q  <= '0;
                div_q    <= '0;
            end
            else if (m_busy_q)
            begin
                div_q <= half_tick ? 3'h0 : div_q + 3'h1;
                // miso is taken as sclk falls: pin register plus synchroniser lag
                // (three cycles) outlasts the fast half period
                if (half_tick && !sclk_q)
                begin
                    sclk_q <= 1'b1;
                end
                else if (half_tick)
                begin
                    sclk_q  <= 1'b0;
                    m_rx_q  <= {m_rx_q[6:0], pin_s[PIN_MISO]};
                    m_tx_q  <= {m_tx_q[6:0], 1'b0};
                    m_bit_q <= m_bit_q + 3'h1;
                    if (m_bit_q == LAST_BIT)
                    begin
                        m_busy_q <= 1'b0;
                        m_done_q <= 1'b1;
                    end
                end
            end
        end
    end

    // ==================================================================
    // slave byte engine; sclk is oversampled, so the processor clock
    // must stay well below a quarter of sys_clk
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_sclk_prev_q <= 1'b0;
            s_bit_q       <= '0;
            s_rx_q        <= '0;
            s_done_q      <= 1'b0;
        end
        else
        begin
            s_sclk_prev_q <= pin_s[PIN_SCLK];
            s_done_q      <= 1'b0;
            if (!s_active)
                s_bit_q <= '0;
            else if (s_rise)
            begin
                s_rx_q   <= {s_rx_q[6:0], pin_s[PIN_MOSI]};
                s_bit_q  <= s_bit_q + 3'h1;
                s_done_q <= (s_bit_q == LAST_BIT);
            end
        end
    end

    // ==================================================================
    // sequencer and image parser
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q        <= ST_IDLE;
            next_q      <= ST_IDLE;
            ph_q        <= PH_HDR;
            wait_cnt_q  <= '0;
            cmd_idx_q   <= '0;
            len_q       <= '0;
            len_hi_q    <= '0;
            sum_q       <= '0;
            retry_q     <= '0;
            fast_q      <= 1'b0;
            user_cnt_q  <= '0;
            master_mode <= 1'b0;
            cfg_data    <= '0;
            cfg_valid   <= 1'b0;
            cfg_done    <= 1'b0;
            cfg_fail    <= 1'b0;
            user_mode   <= 1'b0;
        end
        else if (!rst_n_s)
        begin
            st_q      <= ST_IDLE;
            cfg_valid <= 1'b0;
            cfg_done  <= 1'b0;
            cfg_fail  <= 1'b0;
            user_mode <= 1'b0;
        end
        else
        begin
            cfg_valid <= 1'b0;
            unique case (st_q)
                ST_IDLE:
                begin
                    master_mode <= pin_s[PIN_CS];
                    st_q        <= pin_s[PIN_CS] ? ST_WAIT : ST_STREAM;
                    ph_q        <= PH_HDR;
                    sum_q       <= '0;
                    retry_q     <= '0;
                    fast_q      <= 1'b0;
                    wait_cnt_q  <= '0;
                    cmd_idx_q   <= '0;
                    user_cnt_q  <= '0;
                end
                ST_WAIT:
                begin
                    wait_cnt_q <= wait_cnt_q + 16'h0001;
                    if (wait_end)
                        st_q <= ST_CMD;
                end
                ST_CMD:
                begin
                    if (byte_done)
                    begin
                        cmd_idx_q <= cmd_idx_q + 2'h1;
                        if (cmd_idx_q == CMD_LAST_IDX)
                            st_q <= ST_STREAM;
                    end
                end
                ST_STREAM:
                begin
                    if (finish && master_mode)
                    begin
                        st_q       <= ST_GAP;
                        next_q     <= ST_PDN;
                        wait_cnt_q <= '0;
                    end
                    else if (finish)
                    begin
                        st_q     <= ST_DONE;
                        cfg_done <= 1'b1;
                    end
                    else if (sum_bad && retry_q == MAX_RETRY)
                        st_q <= ST_FAIL;
                    else if (sum_bad)
                    begin
                        retry_q    <= retry_q + 3'h1;
                        ph_q       <= PH_HDR;
                        sum_q      <= '0;
                        fast_q     <= 1'b0;
                        cmd_idx_q  <= '0;
                        wait_cnt_q <= '0;
                        next_q     <= ST_CMD;
                        st_q       <= master_mode ? ST_GAP : ST_STREAM;
                    end
                    else if (got)
                    begin
                        unique case (ph_q)
                            PH_HDR:
                            begin
                                fast_q <= master_mode && rx_byte[FAST_FLAG_BIT];
                                ph_q   <= PH_LENH;
                            end
                            PH_LENH:
                            begin
                                len_hi_q <= rx_byte;
                                ph_q     <= PH_LENL;
                            end
                            PH_LENL:
                            begin
                                len_q <= len_full;
                                ph_q  <= (len_full == ZERO_LEN) ? PH_SUM : PH_DATA;
                            end
                            PH_DATA:
                            begin
                                cfg_data  <= rx_byte;
                                cfg_valid <= 1'b1;
                                sum_q     <= sum_q + rx_byte;
                                len_q     <= len_q - ONE_LEN;
                                if (len_q == ONE_LEN)
                                    ph_q <= PH_SUM;
                            end
                            PH_SUM:
                                ph_q <= PH_SUM;
                        endcase
                    end
                end
                ST_GAP:
                begin
                    wait_cnt_q <= wait_cnt_q + 16'h0001;
                    if (gap_end)
                    begin
                        st_q     <= next_q;
                        cfg_done <= (next_q == ST_DONE);
                    end
                end
                ST_PDN:
                begin
                    if (byte_done)
                    begin
                        st_q       <= ST_GAP;
                        next_q     <= ST_DONE;
                        wait_cnt_q <= '0;
                    end
                end
                ST_DONE:
                begin
                    if (user_cnt_q == USER_DELAY_CYC - 5'h01)
                        user_mode <= 1'b1;
                    else
                        user_cnt_q <= user_cnt_q + 5'h01;
                end
                ST_FAIL:
                    cfg_fail <= 1'b1;
            endcase
        end
    end

endmodule // scl_loader

`default_nettype wire

// [tb/scl_properties.sv]
// scl_properties: port-level checks of the spi configuration loader.
// assumes it is bound into scl_loader and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module scl_properties
    import scl_pkg::*;
#(
    parameter int START_WAIT = START_WAIT_CYC
) (
    // clock and reset
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic             config_reset_n,
    // pins
    input wire logic [PIN_N-1:0] pin_i,
    input wire logic [PIN_N-1:0] pin_o,
    input wire logic [PIN_N-1:0] pin_oe_n,
    input wire logic [PIN_N-1:0] user_pin_o,
    input wire logic [PIN_N-1:0] user_pin_oe_n,
    input wire logic [PIN_N-1:0] user_pin_i,
    // status
    input wire logic [7:0]       cfg_data,
    input wire logic             cfg_valid,
    input wire logic             cfg_done,
    input wire logic             cfg_fail,
    input wire logic             user_mode,
    input wire logic             master_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ==================================================================
    // helper counters: sclk high length, falls per frame, time since release
    logic [3:0]  hi_q;
    logic [5:0]  fall_q;
    logic [15:0] wait_q;
    logic        sclk_q;
    wire         sclk_fell = sclk_q & ~pin_o[PIN_SCLK];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hi_q   <= 4'h0;
            fall_q <= 6'h00;
            wait_q <= 16'h0000;
            sclk_q <= 1'b0;
        end else begin
            hi_q   <= pin_o[PIN_SCLK] ? hi_q + 4'h1 : 4'h0;
            sclk_q <= pin_o[PIN_SCLK];
            fall_q <= pin_o[PIN_CS] ? 6'h00 : fall_q + 6'(sclk_fell && fall_q != 6'h3F);
            wait_q <= !config_reset_n ? 16'h0000 : wait_q + 16'(wait_q != 16'hFFFF);
        end
    end

    // ==================================================================
    // assertions
    AST_IDLE_RESET: assert property (!config_reset_n [*5] |->
        pin_oe_n[2:0] == 3'h7 && !cfg_done && !user_mode) else $error("pins driven in reset");
    AST_SLAVE_NO_DRIVE: assert property (!master_mode && !user_mode |->
        pin_oe_n == 4'hF) else $error("slave loader drives a pin");
    AST_MISO_FREE: assert property (!user_mode |-> pin_oe_n[PIN_MISO])
        else $error("loader drives miso");
    AST_START_WAIT: assert property ($rose(pin_o[PIN_SCLK]) && !pin_oe_n[PIN_SCLK] |->
        wait_q >= START_WAIT) else $error("sclk rose before start wait");
    AST_SCLK_RATE: assert property (!pin_oe_n[PIN_SCLK] && $fell(pin_o[PIN_SCLK]) |->
        hi_q == 4'(HALF_SLOW) || hi_q == 4'(HALF_FAST)) else $error("sclk half period off");
    AST_HEADER_SLOW: assert property (sclk_fell && fall_q == 6'd39 && master_mode |->
        hi_q == 4'(HALF_SLOW)) else $error("header not read at slow rate");
    AST_USER_DELAY: assert property ($rose(cfg_done) |-> ##15 !user_mode ##1 user_mode)
        else $error("user mode delay wrong");
    AST_HANDOVER: assert property (user_mode && $past(user_mode) |->
        pin_o == $past(user_pin_o) && pin_oe_n == $past(user_pin_oe_n))
        else $error("pins not handed to user");
    AST_FAIL_HOLD: assert property (cfg_fail |-> !cfg_done && !user_mode)
        else $error("fail with done or user mode");
    AST_PDN_CS: assert property ($rose(cfg_done) && master_mode |->
        pin_o[PIN_CS] && !pin_oe_n[PIN_CS]) else $error("cs not high at done");

    COV_MASTER_DONE: cover property ($rose(cfg_done) && master_mode);
    COV_SLAVE_DONE: cover property ($rose(cfg_done) && !master_mode);
    COV_FAIL: cover property ($rose(cfg_fail));
endmodule // scl_properties

bind scl_loader scl_properties #(.START_WAIT(START_WAIT)) scl_properties_inst (
    .sys_clk(sys_clk), .rst(rst), .config_reset_n(config_reset_n), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .user_pin_o(user_pin_o),
    .user_pin_oe_n(user_pin_oe_n), .user_pin_i(user_pin_i), .cfg_data(cfg_data),
    .cfg_valid(cfg_valid), .cfg_done(cfg_done), .cfg_fail(cfg_fail),
    .user_mode(user_mode), .master_mode(master_mode));

`default_nettype wire

// [tb/scl_prom_model.sv]
// scl_prom_model: behavioural serial prom, mode 0, read and power-down.
// assumes the bench fills mem and powers it up while config reset is low.
`timescale 1ns/1ps
`default_nettype none

module scl_prom_model (
    // spi pins
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0]  mem [0:131071];
    logic [31:0] sh;
    logic [7:0]  out_q;
    logic [16:0] addr;
    int          bit_cnt = 0;
    int          reads   = 0;
    logic        asleep  = 1'b0;
    logic        active  = 1'b0;
    initial miso = 1'b0;

    // ==================================================================
    // a deselected or sleeping prom lets miso wander, so stale bits never match
    always @(negedge cs_n) begin
        bit_cnt = 0;
        active  = 1'b0;
    end
    always @(posedge cs_n) begin
        if (bit_cnt == 8 && sh[7:0] == 8'hB9)
            asleep = 1'b1;
        miso = ~miso;
    end
    always @(posedge sclk) begin
        if (!cs_n && !asleep) begin
            sh      = {sh[30:0], mosi};
            bit_cnt = bit_cnt + 1;
            if (bit_cnt == 32 && sh[31:24] == 8'h03) begin
                reads  = reads + 1;
                addr   = sh[16:0];
                active = 1'b1;
            end
        end
    end
    always @(negedge sclk) begin
        if (!cs_n && active && !asleep) begin
            if ((bit_cnt - 32) % 8 == 0) begin
                out_q = mem[addr];
                addr  = addr + 17'h1;
            end
            miso = out_q[7 - (bit_cnt - 32) % 8];
        end else
            miso = ~miso;
    end
endmodule // scl_prom_model

`default_nettype wire

// [tb/testbench.sv]
// testbench: master loads from the prom model, slave loads from a host task.
// assumes the loader of hdl/ with a shortened start wait.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import scl_pkg::*;
    localparam int SW = 20;

    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       config_reset_n = 1'b0;
    logic       host_cs = 1'b1;
    logic       host_sclk = 1'b0;
    logic       host_mosi = 1'b0;
    logic       prom_on = 1'b1;
    logic [3:0] user_pin_o = 4'h0;
    logic [3:0] user_pin_oe_n = 4'hF;
    wire  [3:0] pin_o, pin_oe_n, user_pin_i, ext, lvl;
    wire  [7:0] cfg_data;
    wire        cfg_valid, cfg_done, cfg_fail, user_mode, master_mode, prom_miso;
    int         err_count = 0;
    int         check_count = 0;
    logic [7:0] got[$];

    always #10 sys_clk = ~sys_clk;
    assign ext = {prom_miso, host_mosi, host_sclk, host_cs};
    assign lvl = (pin_oe_n & ext) | (~pin_oe_n & pin_o);
    always @(posedge sys_clk) if (cfg_valid === 1'b1) got.push_back(cfg_data);

    scl_loader #(.START_WAIT(SW)) scl_loader_inst (
        .sys_clk(sys_clk), .rst(rst), .config_reset_n(config_reset_n), .pin_i(lvl),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .user_pin_o(user_pin_o),
        .user_pin_oe_n(user_pin_oe_n), .user_pin_i(user_pin_i), .cfg_data(cfg_data),
        .cfg_valid(cfg_valid), .cfg_done(cfg_done), .cfg_fail(cfg_fail),
        .user_mode(user_mode), .master_mode(master_mode));
    scl_prom_model prom_inst (.cs_n(lvl[0] | ~prom_on), .sclk(lvl[1]), .mosi(lvl[2]),
        .miso(prom_miso));

    // ==================================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic stop_test();
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic host_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            host_mosi = b[i];
            tick(4);
            host_sclk = 1'b1;
            tick(4);
            host_sclk = 1'b0;
        end
    endtask
    // pulse config reset with chip select at the mode level, then feed the image
    task automatic run_load(input logic master, input logic [7:0] img[$]);
        user_pin_oe_n = 4'hF;
        host_cs = master;
        prom_on = master;
        for (int i = 0; i < img.size(); i++) prom_inst.mem[i] = img[i];
        config_reset_n = 1'b0;
        prom_inst.asleep = 1'b0;
        prom_inst.reads = 0;
        tick(6);
        check("oe_in_reset", 16'h0007, {13'h0, pin_oe_n[2:0]});
        check("done_in_reset", 16'h0000, {15'h0, cfg_done});
        config_reset_n = 1'b1;
        tick(6);
        got.delete();
        check("mode", {15'h0, master}, {15'h0, master_mode});
        if (!master)
            foreach (img[i]) host_byte(img[i]);
        for (int i = 0; i < 30000 && cfg_done !== 1'b1 && cfg_fail !== 1'b1; i++) tick(1);
        host_cs = 1'b1;
        if (cfg_done !== 1'b1 && cfg_fail !== 1'b1) begin
            err_count++;
            stop_test();
        end
        tick(20);
    endtask
    task automatic check_bytes(input logic [7:0] exp[$]);
        check("byte_count", 16'(exp.size()), 16'(got.size()));
        foreach (exp[i]) if (i < got.size()) check("byte", {8'h0, exp[i]}, {8'h0, got[i]});
    endtask

    // ==================================================================
    // scenarios
    task automatic master_good();
        run_load(1'b1, '{8'h01, 8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'h16});
        check("done", 16'h0001, {15'h0, cfg_done});
        check_bytes('{8'hA1, 8'hB2, 8'hC3});
        check("prom_asleep", 16'h0001, {15'h0, prom_inst.asleep});
        check("user_mode", 16'h0001, {15'h0, user_mode});
        user_pin_o = 4'h5;
        user_pin_oe_n = 4'h6;
        host_sclk = 1'b1;
        host_mosi = 1'b0;
        tick(5);
        check("user_oe", 16'h0006, {12'h0, pin_oe_n});
        check("user_in", 16'h0003, {12'h0, user_pin_i});
        host_sclk = 1'b0;
    endtask
    // a stored sum one off: first load and five retries, then give up
    task automatic master_bad();
        run_load(1'b1, '{8'h00, 8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'h17});
        check("fail", 16'h0001, {15'h0, cfg_fail});
        check("done_low", 16'h0000, {15'h0, cfg_done});
        check("attempts", 16'd6, 16'(prom_inst.reads));
        check("user_held", 16'h0000, {15'h0, user_mode});
    endtask
    task automatic slave_good();
        run_load(1'b0, '{8'h00, 8'h00, 8'h02, 8'h5A, 8'h0F, 8'h69});
        check("slave_done", 16'h0001, {15'h0, cfg_done});
        check_bytes('{8'h5A, 8'h0F});
    endtask
    // all ones, as a swapped data pair reads, is an empty request
    task automatic slave_empty();
        run_load(1'b0, '{8'hFF, 8'hFF, 8'hFF});
        check("empty_done", 16'h0001, {15'h0, cfg_done});
        check("empty_bytes", 16'h0000, 16'(got.size()));
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        tick(4);
        master_good();
        master_bad();
        slave_good();
        slave_empty();
        master_good();
        stop_test();
    end
endmodule // testbench

`default_nettype wire
